// [src/e3ri_pkg.sv]
// Constants for the receive E3 defect-change interrupt block
package e3ri_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] REG_BLOCK_EN_IDX = 8'h04;
  localparam logic [7:0] REG_CFG_STAT_IDX = 8'h11;
  localparam logic [7:0] REG_INT_EN_IDX = 8'h12;
  localparam logic [7:0] REG_INT_FLAG_IDX = 8'h14;

  // Enable and flag bit positions
  localparam int BIT_ALIGN = 4;
  localparam int BIT_OOA = 3;
  localparam int BIT_FLOSS = 2;
  localparam int BIT_SLOSS = 1;
  localparam int BIT_ALARM = 0;
  localparam int SRC_W = 5;

  // Block enable bit positions
  localparam int BLK_RX_BIT = 7;
  localparam int BLK_TX_BIT = 1;
  localparam int BLK_SEC_BIT = 0;

  // Configuration and condition bit positions
  localparam int CFG_ALGO_BIT = 7;
  localparam int CFG_FLOSS_BIT = 6;
  localparam int CFG_OOA_BIT = 5;
  localparam int CFG_SLOSS_BIT = 4;
  localparam int CFG_ALARM_BIT = 3;
  localparam int CFG_PLD_BIT = 2;
  localparam int CFG_TMARK_BIT = 1;
  localparam int CFG_FAR_END_RECEIVE_FAILURE_BIT = 0;

  // Reset values
  localparam logic [4:0] INT_EN_RESET = 5'h00;
  localparam logic [4:0] INT_FLAG_RESET = 5'h00;
  localparam logic [2:0] BLOCK_EN_RESET = 3'h0;
  localparam logic ALGO_RESET = 1'b0;

  // Detection counts
  localparam int LOS_ZERO_RUN = 32;
  localparam int LOS_CLEAN_BITS = 32;
  localparam int LOS_ZERO_BREAK = 4;
  localparam int OOA_ERR_FRAMES = 4;

  // Timing
  localparam int CLK_MHZ = 40;
  localparam int MS_PERIOD_US = 1000;
  localparam int MS_CYCLES = MS_PERIOD_US * CLK_MHZ;
  localparam int LOF_SHORT_MS = 1;
  localparam int LOF_LONG_MS = 3;

  typedef enum logic [1:0] {FL_IN_FRAME, FL_TIMING, FL_LOST} e3ri_fl_state_type;

endpackage

// [src/e3ri_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module e3ri_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // e3ri_sync
`default_nettype wire

// [src/e3ri_rx_defect_irq.sv]
// Receive E3 defect-change interrupts with APB register access
//
// Operation
// [R1] Signal loss change interrupts on declare and clear
// [R2] Signal loss change drives interrupt request low
// [R3] Signal loss change sets flag bit one
// [R4] Flag register bits clear when read
// [R5] Live signal loss readable at bit four
// [R6] Host sends far-end failure while defect true
// [R7] Out-of-alignment change interrupts on declare, clear
// [R8] Four consecutive errored frames declare out-of-alignment
// [R9] Entering in-frame state clears out-of-alignment
// [R10] Enable bit three gates out-of-alignment interrupt
// [R11] Enable register holds five read-write enables
// [R12] Out-of-alignment change asserts request, sets bit three
// [R13] Live out-of-alignment readable at bit five
// [R14] Configuration register: algorithm select plus conditions
// [R15] Frame loss change interrupts on declare, clear
// [R16] Frame loss after 1ms or 3ms unresolved
// [R17] Returning in-frame clears frame loss
// [R18] Enable bit one gates signal loss interrupt
// [R19] Loss pin or 32 zeros declare
// [R20] Pin low or 32 clean bits clear; the code needs the pin low and, after a 32-zero declare, 32 clean bits
// [R21] Block enable bit seven gates receive interrupts
// [R22] Request stays low while enabled flags set
`timescale 1ns/1ps
`default_nettype none
module e3ri_rx_defect_irq
  import e3ri_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line interface
  input wire logic line_signal_loss_input,
  input wire logic rx_bit_strobe,
  input wire logic rx_pos,
  input wire logic rx_neg,
  // Framer
  input wire logic frame_strobe,
  input wire logic frame_bit_error,
  input wire logic framer_in_frame_entry,
  input wire logic alignment_change,
  input wire logic rx_alarm_indication_state,
  input wire logic rx_payload_unstable,
  input wire logic rx_trail_mark,
  input wire logic rx_far_end_failure_state,
  // Host interrupt
  output logic irq_n
);

  localparam int DIV_W = $clog2(MS_CYCLES_P);

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] idx);
    addr_is = (a == {idx[5:0], 2'b00});
  endfunction

  logic pin_loss_sync;
  logic setup_ph;
  logic access_done;
  logic wr_done;
  logic rd_flags_done;
  logic [2:0] block_en_r;
  logic [SRC_W-1:0] int_en_r;
  logic [SRC_W-1:0] flags_r;
  logic [SRC_W-1:0] flags_nxt;
  logic [SRC_W-1:0] set_vec;
  logic algo_r;
  logic [5:0] zero_run_r;
  logic [5:0] clean_cnt_r;
  logic dig_los_r;
  logic dig_los_nxt;
  logic los_r;
  logic los_nxt;
  logic zero_bit;
  logic [2:0] err_cnt_r;
  logic ooa_r;
  logic ooa_nxt;
  e3ri_fl_state_type fl_state_r;
  e3ri_fl_state_type fl_state_nxt;
  logic [DIV_W-1:0] ms_div_r;
  logic [1:0] ms_cnt_r;
  logic ms_tick;
  logic [1:0] ms_limit;
  logic floss_r;
  logic floss_nxt;
  logic alarm_r;
  logic irq_pending;

  // Pin crosses into pclk domain first
  e3ri_sync #(.WIDTH(1)) u_loss_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(line_signal_loss_input),
    .sync_out(pin_loss_sync)
  );

  // APB phases; answer always in first access cycle
  assign setup_ph = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done = access_done && pwrite;
  assign rd_flags_done = access_done && !pwrite && addr_is(paddr, REG_INT_FLAG_IDX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= 1'b0;
      if (setup_ph) begin
        prdata <= 32'h0000_0000;
        if (addr_is(paddr, REG_BLOCK_EN_IDX)) begin
          prdata[BLK_RX_BIT] <= block_en_r[2];
          prdata[BLK_TX_BIT] <= block_en_r[1];
          prdata[BLK_SEC_BIT] <= block_en_r[0];
        end else if (addr_is(paddr, REG_CFG_STAT_IDX)) begin
          prdata[CFG_ALGO_BIT] <= algo_r; // [R14]
          prdata[CFG_FLOSS_BIT] <= floss_r; // [R14]
          prdata[CFG_OOA_BIT] <= ooa_r; // [R13]
          prdata[CFG_SLOSS_BIT] <= los_r; // [R5]
          prdata[CFG_ALARM_BIT] <= rx_alarm_indication_state;
          prdata[CFG_PLD_BIT] <= rx_payload_unstable;
          prdata[CFG_TMARK_BIT] <= rx_trail_mark;
          prdata[CFG_FAR_END_RECEIVE_FAILURE_BIT] <= rx_far_end_failure_state;
        end else if (addr_is(paddr, REG_INT_EN_IDX)) begin
          prdata[SRC_W-1:0] <= int_en_r; // [R11]
        end else if (addr_is(paddr, REG_INT_FLAG_IDX)) begin
          prdata[SRC_W-1:0] <= flags_r; // [R4]
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Writable registers; read-only bits ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_en_r <= BLOCK_EN_RESET;
      int_en_r <= INT_EN_RESET;
      algo_r <= ALGO_RESET;
    end else if (wr_done) begin
      if (addr_is(paddr, REG_BLOCK_EN_IDX)) begin
        block_en_r <= {pwdata[BLK_RX_BIT], pwdata[BLK_TX_BIT], pwdata[BLK_SEC_BIT]}; // [R21]
      end
      if (addr_is(paddr, REG_INT_EN_IDX)) begin
        int_en_r <= pwdata[SRC_W-1:0]; // [R11]
      end
      if (addr_is(paddr, REG_CFG_STAT_IDX)) begin
        algo_r <= pwdata[CFG_ALGO_BIT]; // [R14]
      end
    end
  end

  // Signal loss detection from line data
  assign zero_bit = !rx_pos && !rx_neg;

  always_comb begin
    dig_los_nxt = dig_los_r;
    if (rx_bit_strobe) begin
      if (zero_bit && (zero_run_r == 6'(LOS_ZERO_RUN - 1))) begin
        dig_los_nxt = 1'b1; // [R19]
      end else if (clean_cnt_r == 6'(LOS_CLEAN_BITS - 1)
                   && !(zero_bit && (zero_run_r >= 6'(LOS_ZERO_BREAK - 1)))) begin
        dig_los_nxt = 1'b0; // [R20]
      end
    end
    los_nxt = pin_loss_sync || dig_los_nxt; // [R19] [R20]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_run_r <= 6'h00;
      clean_cnt_r <= 6'h00;
      dig_los_r <= 1'b0;
      los_r <= 1'b0;
    end else begin
      dig_los_r <= dig_los_nxt;
      los_r <= los_nxt;
      if (rx_bit_strobe) begin
        if (!zero_bit) begin
          zero_run_r <= 6'h00;
        end else if (zero_run_r != 6'(LOS_ZERO_RUN)) begin
          zero_run_r <= zero_run_r + 6'h01;
        end
        // A run of four zeros restarts the clean window
        if (zero_bit && (zero_run_r >= 6'(LOS_ZERO_BREAK - 1))) begin
          clean_cnt_r <= 6'h00; // [R20]
        end else if (clean_cnt_r != 6'(LOS_CLEAN_BITS)) begin
          clean_cnt_r <= clean_cnt_r + 6'h01;
        end
      end
    end
  end

  // Out-of-alignment from framing errors
  always_comb begin
    ooa_nxt = ooa_r;
    if (framer_in_frame_entry) begin
      ooa_nxt = 1'b0; // [R9]
    end else if (frame_strobe && frame_bit_error
                 && (err_cnt_r == 3'(OOA_ERR_FRAMES - 1))) begin
      ooa_nxt = 1'b1; // [R8]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt_r <= 3'h0;
      ooa_r <= 1'b0;
    end else begin
      ooa_r <= ooa_nxt;
      if (framer_in_frame_entry) begin
        err_cnt_r <= 3'h0;
      end else if (frame_strobe) begin
        if (!frame_bit_error) begin
          err_cnt_r <= 3'h0; // [R8]
        end else if (err_cnt_r != 3'(OOA_ERR_FRAMES)) begin
          err_cnt_r <= err_cnt_r + 3'h1;
        end
      end
    end
  end

  // Frame loss timer; millisecond enable runs only while timing
  assign ms_tick = (fl_state_r == FL_TIMING) && (ms_div_r == DIV_W'(MS_CYCLES_P - 1));
  assign ms_limit = algo_r ? 2'(LOF_LONG_MS) : 2'(LOF_SHORT_MS);

  always_comb begin
    fl_state_nxt = fl_state_r;
    case (fl_state_r)
      FL_IN_FRAME: begin
        if (ooa_r && !framer_in_frame_entry) begin
          fl_state_nxt = FL_TIMING;
        end
      end
      FL_TIMING: begin
        if (framer_in_frame_entry) begin
          fl_state_nxt = FL_IN_FRAME;
        end else if (ms_tick && (ms_cnt_r + 2'h1 >= ms_limit)) begin
          fl_state_nxt = FL_LOST; // [R16]
        end
      end
      FL_LOST: begin
        if (framer_in_frame_entry) begin
          fl_state_nxt = FL_IN_FRAME; // [R17]
        end
      end
      default: fl_state_nxt = FL_IN_FRAME;
    endcase
    floss_nxt = (fl_state_nxt == FL_LOST);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_state_r <= FL_IN_FRAME;
      ms_div_r <= '0;
      ms_cnt_r <= 2'h0;
      floss_r <= 1'b0;
    end else begin
      fl_state_r <= fl_state_nxt;
      floss_r <= floss_nxt;
      if (fl_state_r != FL_TIMING) begin
        ms_div_r <= '0;
        ms_cnt_r <= 2'h0;
      end else if (ms_tick) begin
        ms_div_r <= '0;
        ms_cnt_r <= ms_cnt_r + 2'h1;
      end else begin
        ms_div_r <= ms_div_r + DIV_W'(1);
      end
    end
  end

  // Change events, gated by source enables
  always_comb begin
    set_vec = '0;
    set_vec[BIT_ALIGN] = alignment_change && int_en_r[BIT_ALIGN];
    set_vec[BIT_OOA] = (ooa_nxt != ooa_r) && int_en_r[BIT_OOA]; // [R7] [R10] [R12]
    set_vec[BIT_FLOSS] = (floss_nxt != floss_r) && int_en_r[BIT_FLOSS]; // [R15]
    set_vec[BIT_SLOSS] = (los_nxt != los_r) && int_en_r[BIT_SLOSS]; // [R1] [R3] [R18]
    set_vec[BIT_ALARM] = (rx_alarm_indication_state != alarm_r) && int_en_r[BIT_ALARM];
    // A new event in the access cycle beats the read that clears it
    flags_nxt = (flags_r & ~{SRC_W{rd_flags_done}}) | set_vec; // [R4]
  end

  assign irq_pending = block_en_r[2] && |(flags_r & int_en_r); // [R21] [R22]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= INT_FLAG_RESET;
      alarm_r <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      flags_r <= flags_nxt;
      alarm_r <= rx_alarm_indication_state;
      irq_n <= !irq_pending; // [R2] [R12] [R22]
    end
  end

  chk_los_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    (los_nxt != los_r) && int_en_r[BIT_SLOSS] |=> flags_r[BIT_SLOSS] && (los_r == $past(los_nxt)))
    else $error("signal loss change did not set its flag");

  chk_irq_low_pending: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    block_en_r[2] && |(flags_r & int_en_r) |=> !irq_n)
    else $error("interrupt request not low with enabled flag");

  chk_irq_high_idle: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
    !(block_en_r[2] && |(flags_r & int_en_r)) |=> irq_n)
    else $error("interrupt request low with nothing pending");

  chk_ooa_declare_four: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    frame_strobe && frame_bit_error && err_cnt_r == 3'h3 && !framer_in_frame_entry |=> ooa_r)
    else $error("fourth errored frame did not declare out-of-alignment");

  chk_ooa_entry_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    framer_in_frame_entry |=> !ooa_r ##0 !floss_r)
    else $error("in-frame entry did not clear conditions");

  chk_floss_after_ooa: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    $rose(floss_r) |-> $past(ooa_r) && $past(fl_state_r) == FL_TIMING)
    else $error("frame loss declared without timed out-of-alignment");

  chk_los_pin_declare: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
    pin_loss_sync |=> los_r)
    else $error("loss pin did not declare signal loss");

  chk_flag_read_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    rd_flags_done && set_vec == '0 |=> flags_r == '0)
    else $error("flag read did not clear flags");

  chk_ooa_enable_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    !flags_r[BIT_OOA] && !int_en_r[BIT_OOA] |=> !flags_r[BIT_OOA])
    else $error("disabled out-of-alignment flag was set");

  chk_cfg_live_read: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    setup_ph && addr_is(paddr, REG_CFG_STAT_IDX)
    |=> pready && prdata[5:4] == {$past(ooa_r), $past(los_r)})
    else $error("live condition readback wrong");

endmodule // e3ri_rx_defect_irq
`default_nettype wire

// [verification/e3ri_line_model.sv]
// Line interface and framer stand-in for the receive defect block
`timescale 1ns/1ps
`default_nettype none
module e3ri_line_model (
  // Clock
  input wire logic pclk,
  // Line interface
  output logic line_signal_loss_input,
  output logic rx_bit_strobe,
  output logic rx_pos,
  output logic rx_neg,
  // Framer
  output logic frame_strobe,
  output logic frame_bit_error,
  output logic framer_in_frame_entry,
  output logic alignment_change,
  // Live framer levels
  output logic rx_alarm_indication_state,
  output logic rx_payload_unstable,
  output logic rx_trail_mark,
  output logic rx_far_end_failure_state
);
  initial begin
    line_signal_loss_input = 1'b0;
    rx_bit_strobe = 1'b0;
    rx_pos = 1'b1;
    rx_neg = 1'b1;
    frame_strobe = 1'b0;
    frame_bit_error = 1'b0;
    framer_in_frame_entry = 1'b0;
    alignment_change = 1'b0;
    {rx_alarm_indication_state, rx_payload_unstable} = 2'h0;
    {rx_trail_mark, rx_far_end_failure_state} = 2'h0;
  end

  // Line bits, msb of the pattern first; ones go on rx_pos at even positions and rx_neg at odd ones, both lines carry the inverted bit between strobes
  task automatic bits(input int n, input logic [3:0] pat);
    logic b;
    for (int i = 0; i < n; i++) begin
      b = pat[3 - i % 4];
      @(posedge pclk);
      rx_bit_strobe <= 1'b1;
      rx_pos <= b && (i % 2 == 0);
      rx_neg <= b && (i % 2 == 1);
      @(posedge pclk);
      rx_bit_strobe <= 1'b0;
      rx_pos <= ~b;
      rx_neg <= ~b;
    end
  endtask

  task automatic frames(input int n, input logic err);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      frame_strobe <= 1'b1;
      frame_bit_error <= err;
      @(posedge pclk);
      frame_strobe <= 1'b0;
      frame_bit_error <= ~err;
    end
  endtask

  // One-cycle framer event: alignment change or in-frame entry
  task automatic pulse(input logic align);
    @(posedge pclk);
    alignment_change <= align;
    framer_in_frame_entry <= ~align;
    @(posedge pclk);
    alignment_change <= 1'b0;
    framer_in_frame_entry <= 1'b0;
  endtask

  task automatic pin(input logic v);
    @(posedge pclk);
    line_signal_loss_input <= v;
  endtask

  task automatic levels(input logic [3:0] v);
    @(posedge pclk);
    rx_alarm_indication_state <= v[3];
    rx_payload_unstable <= v[2];
    rx_trail_mark <= v[1];
    rx_far_end_failure_state <= v[0];
  endtask
endmodule // e3ri_line_model
`default_nettype wire

// [verification/test_e3ri_rx_defect_irq.sv]
// Self-checking bench for the receive defect-change interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_e3ri_rx_defect_irq import e3ri_pkg::*;;
  // Short millisecond keeps the frame loss timers brief
  localparam int MS_SIM = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic line_signal_loss_input, rx_bit_strobe, rx_pos, rx_neg;
  logic frame_strobe, frame_bit_error, framer_in_frame_entry, alignment_change;
  logic rx_alarm_indication_state, rx_payload_unstable;
  logic rx_trail_mark, rx_far_end_failure_state;
  int err_total, samples_checked;

  e3ri_rx_defect_irq #(.MS_CYCLES_P(MS_SIM)) e3ri_rx_defect_irq_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .line_signal_loss_input, .rx_bit_strobe, .rx_pos, .rx_neg, .frame_strobe,
    .frame_bit_error, .framer_in_frame_entry, .alignment_change,
    .rx_alarm_indication_state, .rx_payload_unstable, .rx_trail_mark,
    .rx_far_end_failure_state, .irq_n);

  e3ri_line_model e3ri_line_model_i (.pclk, .line_signal_loss_input, .rx_bit_strobe,
    .rx_pos, .rx_neg, .frame_strobe, .frame_bit_error, .framer_in_frame_entry,
    .alignment_change, .rx_alarm_indication_state, .rx_payload_unstable,
    .rx_trail_mark, .rx_far_end_failure_state);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk_data(q, 32'(exp));
    chk_pin(e, 1'b0);
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq_n !== exp && n < 64) begin
      @(posedge pclk);
      n++;
    end
    chk_pin(irq_n, exp);
    if (n >= 64) tally_and_finish();
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    err_total = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk_pin(irq_n, 1'b1);
    rd(REG_BLOCK_EN_IDX, 8'h00);
    rd(REG_CFG_STAT_IDX, 8'h00);
    rd(REG_INT_EN_IDX, 8'h00);
    rd(REG_INT_FLAG_IDX, 8'h00);
    wr(REG_INT_EN_IDX, 32'hffff_ffff);
    rd(REG_INT_EN_IDX, 8'h1f);
    wr(REG_CFG_STAT_IDX, 32'hffff_ffff);
    rd(REG_CFG_STAT_IDX, 8'h80);
    wr(REG_BLOCK_EN_IDX, 32'hffff_ffff);
    rd(REG_BLOCK_EN_IDX, 8'h83);
    apb(1'b0, 8'h13, 32'h0000_0000);
    chk_data(q, 32'h0000_0000);
    chk_pin(e, 1'b1);
    // Live levels, the alarm change flag and the alignment change flag
    e3ri_line_model_i.levels(4'hf);
    rd(REG_CFG_STAT_IDX, 8'h8f);
    wait_irq(1'b0);
    rd(REG_INT_FLAG_IDX, 8'h01);
    wait_irq(1'b1);
    e3ri_line_model_i.levels(4'h0);
    rd(REG_INT_FLAG_IDX, 8'h01);
    e3ri_line_model_i.pulse(1'b1);
    rd(REG_INT_FLAG_IDX, 8'h10);
    // Signal loss with its source disabled
    wr(REG_INT_EN_IDX, 32'h0000_0000);
    e3ri_line_model_i.pin(1'b1);
    repeat (8) @(posedge pclk);
    chk_pin(irq_n, 1'b1);
    rd(REG_INT_FLAG_IDX, 8'h00);
    rd(REG_CFG_STAT_IDX, 8'h90);
    e3ri_line_model_i.pin(1'b0);
    repeat (8) @(posedge pclk);
    rd(REG_INT_FLAG_IDX, 8'h00);
    // Block gate holds back the request until opened
    wr(REG_INT_EN_IDX, 32'h0000_0002);
    wr(REG_BLOCK_EN_IDX, 32'h0000_0000);
    e3ri_line_model_i.pin(1'b1);
    repeat (8) @(posedge pclk);
    chk_pin(irq_n, 1'b1);
    wr(REG_BLOCK_EN_IDX, 32'h0000_0080);
    wait_irq(1'b0);
    rd(REG_CFG_STAT_IDX, 8'h90);
    rd(REG_INT_FLAG_IDX, 8'h02);
    wait_irq(1'b1);
    e3ri_line_model_i.pin(1'b0);
    wait_irq(1'b0);
    rd(REG_CFG_STAT_IDX, 8'h80);
    rd(REG_INT_FLAG_IDX, 8'h02);
    // Signal loss from the line bits; clean pattern uses both rails
    e3ri_line_model_i.bits(31, 4'h0);
    rd(REG_CFG_STAT_IDX, 8'h80);
    e3ri_line_model_i.bits(1, 4'h0);
    rd(REG_CFG_STAT_IDX, 8'h90);
    rd(REG_INT_FLAG_IDX, 8'h02);
    e3ri_line_model_i.bits(31, 4'h9);
    rd(REG_CFG_STAT_IDX, 8'h90);
    e3ri_line_model_i.bits(1, 4'h9);
    rd(REG_CFG_STAT_IDX, 8'h80);
    rd(REG_INT_FLAG_IDX, 8'h02);
    // Out of alignment needs four errored frames in a row
    wr(REG_INT_EN_IDX, 32'h0000_0008);
    e3ri_line_model_i.frames(3, 1'b1);
    e3ri_line_model_i.frames(1, 1'b0);
    e3ri_line_model_i.frames(3, 1'b1);
    rd(REG_CFG_STAT_IDX, 8'h80);
    e3ri_line_model_i.frames(1, 1'b1);
    wait_irq(1'b0);
    rd(REG_CFG_STAT_IDX, 8'ha0);
    rd(REG_INT_FLAG_IDX, 8'h08);
    e3ri_line_model_i.pulse(1'b0);
    rd(REG_CFG_STAT_IDX, 8'h80);
    rd(REG_INT_FLAG_IDX, 8'h08);
    // Frame loss, short period then long period
    wr(REG_CFG_STAT_IDX, 32'h0000_0000);
    wr(REG_INT_EN_IDX, 32'h0000_0004);
    e3ri_line_model_i.frames(4, 1'b1);
    rd(REG_CFG_STAT_IDX, 8'h20);
    repeat (24) @(posedge pclk);
    rd(REG_CFG_STAT_IDX, 8'h60);
    wait_irq(1'b0);
    rd(REG_INT_FLAG_IDX, 8'h04);
    e3ri_line_model_i.pulse(1'b0);
    rd(REG_CFG_STAT_IDX, 8'h00);
    rd(REG_INT_FLAG_IDX, 8'h04);
    wr(REG_CFG_STAT_IDX, 32'h0000_0080);
    e3ri_line_model_i.frames(4, 1'b1);
    repeat (30) @(posedge pclk);
    rd(REG_CFG_STAT_IDX, 8'ha0);
    repeat (30) @(posedge pclk);
    rd(REG_CFG_STAT_IDX, 8'he0);
    e3ri_line_model_i.pulse(1'b0);
    rd(REG_CFG_STAT_IDX, 8'h80);
    wait_irq(1'b0);
    // Reset in mid-run drops the request and clears every register
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_pin(irq_n, 1'b1);
    presetn <= 1'b1;
    rd(REG_INT_EN_IDX, 8'h00);
    rd(REG_INT_FLAG_IDX, 8'h00);
    rd(REG_CFG_STAT_IDX, 8'h00);
    rd(REG_BLOCK_EN_IDX, 8'h00);
    tally_and_finish();
  end
endmodule // test_e3ri_rx_defect_irq
`default_nettype wire
